// [hw/olc_top.sv]
`timescale 1ns/10ps
// What this block does
// - drive slave relay output; high powers the slave outlets.
// - drive separate master relay output for the master outlet.
// - reset initialises flags and variables, then goes to idle.
// - idle only advances to the timeout check.
// - on measurement timeout set no-load flag, go to slave control.
// - no timeout clears the flag, goes to measurement processing.
// - pulse frequency found by measuring interval between input pulses.
// - interval samples filtered with a trimmed mean.
// - compare reading to threshold, set slave-enable flag, go to slave control.
// - slave control sets relay from enable and timeout flags, back to idle.
// - illegal state enters exception state, reinitialises, then idle.
// - watchdog runs from reset onward.
// - logic runs from a single core clock.
// - power threshold defaults to 30 watts.
// - 20 ms tick; 200 ms without pulse means no load.
module olc_top #(
    parameter int TICK_CYC = olc_pkg::TICK_CYC,
    parameter int WDT_CYC = olc_pkg::WDT_CYC,
    // interval in cycles that equals the threshold power; arbitrary calibration
    parameter logic [olc_pkg::IVL_W-1:0] THRESH_IVL = 24'h0f4240
) (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic meter_pulse_i,
    input wire logic master_enable_i,
    output logic slave_relay_drive_o,
    output logic master_relay_drive_o,
    output logic noload_o,
    output logic [olc_pkg::IVL_W-1:0] reading_o,
    output logic wdt_reset_o
);
    localparam int W = olc_pkg::IVL_W;
    localparam int N = olc_pkg::SAMP_N;
    localparam int SW = W + 3;

    olc_pkg::olc_state_t state_reg;
    olc_pkg::olc_state_t state_next;
    logic [W-1:0] ivl;
    logic ivl_valid;
    logic exc_clear;
    logic [W-1:0] samp_reg [N];
    logic [2:0] nsamp_reg;
    logic [W-1:0] mean_reg;
    logic mean_new_reg;
    logic timeout_reg;
    logic slave_en_reg;
    logic [23:0] tick_cnt_reg;
    logic [3:0] ticks_reg;
    logic [23:0] wdt_cnt_reg;
    olc_pkg::olc_relay_t relay_reg;

    olc_interval #(.IVL_W(W)) u_ivl (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .clear_i(exc_clear),
        .pulse_i(meter_pulse_i),
        .interval_o(ivl),
        .valid_o(ivl_valid)
    );

    // trimmed mean over the captured window
    function automatic logic [W-1:0] trim_mean(input logic [N*W-1:0] s);
        logic [SW-1:0] sum;
        logic [W-1:0] mx;
        logic [W-1:0] mn;
        logic [W-1:0] v;
        sum = '0;
        mx = '0;
        mn = '1;
        for (int i = 0; i < N; i++)
        begin
            v = s[i*W +: W];
            sum = sum + SW'(v);
            if (v > mx)
                mx = v;
            if (v < mn)
                mn = v;
        end
        sum = sum - SW'(mx) - SW'(mn);
        return W'(sum >> olc_pkg::SAMP_LOG2);
    endfunction

    logic [N*W-1:0] samp_flat;
    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_flat
            assign samp_flat[g*W +: W] = samp_reg[g];
        end
    endgenerate

    // shorter interval means more power; a long interval is below threshold
    wire above_thresh = (mean_reg != '0) && (mean_reg < THRESH_IVL);
    wire tick = (tick_cnt_reg == 24'(TICK_CYC - 1));
    wire window_full = (nsamp_reg == 3'(N - 1)) && ivl_valid;
    wire timed_out = (ticks_reg >= 4'(olc_pkg::NOLOAD_TICKS));
    assign exc_clear = (state_reg == olc_pkg::OLC_EXC) || (state_reg == olc_pkg::OLC_INIT);

    // sample window fills by shifting; mean taken once it is full
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            for (int i = 0; i < N; i++)
                samp_reg[i] <= '0;
            nsamp_reg <= 3'h0;
            mean_reg <= '0;
            mean_new_reg <= 1'b0;
        end
        else if (exc_clear)
        begin
            nsamp_reg <= 3'h0;
            mean_reg <= '0;
            mean_new_reg <= 1'b0;
        end
        else
        begin
            if (ivl_valid)
            begin
                samp_reg[0] <= ivl;
                for (int i = 1; i < N; i++)
                    samp_reg[i] <= samp_reg[i-1];
                nsamp_reg <= window_full ? 3'h0 : nsamp_reg + 3'h1;
            end
            if (nsamp_reg == 3'h0 && mean_new_reg)
            begin
                mean_reg <= trim_mean(samp_flat);
                mean_new_reg <= 1'b0;
            end
            else if (window_full)
                mean_new_reg <= 1'b1;
        end
    end

    // 20 ms tick and tick count since the last metering pulse
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            tick_cnt_reg <= 24'h0;
            ticks_reg <= 4'h0;
        end
        else
        begin
            tick_cnt_reg <= tick ? 24'h0 : tick_cnt_reg + 24'h1;
            if (ivl_valid || exc_clear)
                ticks_reg <= 4'h0;
            else if (tick && !timed_out)
                ticks_reg <= ticks_reg + 4'h1;
        end
    end

    // sequencer next state
    always_comb
    begin
        state_next = olc_pkg::OLC_EXC;
        unique case (state_reg)
            olc_pkg::OLC_INIT: state_next = olc_pkg::OLC_IDLE;
            olc_pkg::OLC_IDLE: state_next = olc_pkg::OLC_TOCHK;
            olc_pkg::OLC_TOCHK:
                state_next = timed_out ? olc_pkg::OLC_SLAVE : olc_pkg::OLC_MEAS;
            olc_pkg::OLC_MEAS: state_next = olc_pkg::OLC_SLAVE;
            olc_pkg::OLC_SLAVE: state_next = olc_pkg::OLC_IDLE;
            olc_pkg::OLC_EXC: state_next = olc_pkg::OLC_IDLE;
            default: state_next = olc_pkg::OLC_EXC;
        endcase
    end

    // sequencer, flags and relays
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state_reg <= olc_pkg::OLC_INIT;
            timeout_reg <= 1'b0;
            slave_en_reg <= 1'b0;
            relay_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            relay_reg.master <= master_enable_i;
            if (exc_clear)
            begin
                timeout_reg <= 1'b0;
                slave_en_reg <= 1'b0;
            end
            else if (state_reg == olc_pkg::OLC_TOCHK)
                timeout_reg <= timed_out;
            else if (state_reg == olc_pkg::OLC_MEAS)
                slave_en_reg <= above_thresh;
            else if (state_reg == olc_pkg::OLC_SLAVE)
                relay_reg.slave <= slave_en_reg && !timeout_reg;
        end
    end

    // watchdog runs from reset; kicked each completed pass through idle
    // expiry restarts the count at once, so it never runs past its window
    wire wdt_expire = (wdt_cnt_reg == 24'(WDT_CYC - 1));
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            wdt_cnt_reg <= 24'h0;
            wdt_reset_o <= 1'b0;
        end
        else
        begin
            wdt_reset_o <= wdt_expire;
            if (state_reg == olc_pkg::OLC_IDLE || wdt_expire)
                wdt_cnt_reg <= 24'h0;
            else
                wdt_cnt_reg <= wdt_cnt_reg + 24'h1;
        end
    end

    // registered outputs
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            noload_o <= 1'b0;
            reading_o <= '0;
        end
        else
        begin
            noload_o <= timeout_reg;
            reading_o <= mean_reg;
        end
    end
    assign slave_relay_drive_o = relay_reg.slave;
    assign master_relay_drive_o = relay_reg.master;

    sequence s_tochk;
        state_reg == olc_pkg::OLC_TOCHK;
    endsequence
    a_idle_to_check: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        state_reg == olc_pkg::OLC_IDLE |=> s_tochk) else $error("idle did not advance");
    a_timeout_path: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        s_tochk ##0 timed_out |=> timeout_reg && state_reg == olc_pkg::OLC_SLAVE)
        else $error("timeout path wrong");
    a_meas_path: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        s_tochk ##0 !timed_out |=> !timeout_reg && state_reg == olc_pkg::OLC_MEAS)
        else $error("measure path wrong");
    a_thresh_flag: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        state_reg == olc_pkg::OLC_MEAS |=> slave_en_reg == $past(above_thresh))
        else $error("threshold flag wrong");
    a_slave_relay: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        state_reg == olc_pkg::OLC_SLAVE
        |=> slave_relay_drive_o == $past(slave_en_reg && !timeout_reg)
        ##0 state_reg == olc_pkg::OLC_IDLE) else $error("slave relay wrong");
    a_exc_recover: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        state_reg == olc_pkg::OLC_EXC |=> state_reg == olc_pkg::OLC_IDLE && !timeout_reg)
        else $error("exception not recovered");
    a_noload_limit: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        ticks_reg <= 4'(olc_pkg::NOLOAD_TICKS)) else $error("tick count overran");
    // the edge that releases reset still loads the reset value, so skip that one
    a_master_follow: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        $past(arst_n_i) |-> master_relay_drive_o == $past(master_enable_i))
        else $error("master relay lag");
    a_wdt_bound: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        wdt_cnt_reg < 24'(WDT_CYC)) else $error("watchdog overran");
endmodule

// [hw/olc_pkg.sv]
package olc_pkg;
    // core clock rate
    localparam int CLK_HZ = 10_000_000;
    // tick of the no-load timer channel
    localparam int TICK_MS = 20;
    localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    // no-load window
    localparam int NOLOAD_MS = 200;
    localparam int NOLOAD_TICKS = NOLOAD_MS / TICK_MS;
    // default threshold in watts
    localparam int THRESH_W = 30;
    // interval counter width
    localparam int IVL_W = 24;
    // samples per trimmed mean, power of two plus two
    localparam int SAMP_N = 6;
    localparam int SAMP_LOG2 = 2;
    // watchdog window in cycles
    localparam int WDT_CYC = 1_000_000;

    // controller sequence states
    typedef enum logic [2:0] {
        OLC_INIT = 3'b000,
        OLC_IDLE = 3'b001,
        OLC_TOCHK = 3'b010,
        OLC_MEAS = 3'b011,
        OLC_SLAVE = 3'b100,
        OLC_EXC = 3'b101
    } olc_state_t;

    // relay drive pair
    typedef struct packed {
        logic master;
        logic slave;
    } olc_relay_t;
endpackage

// [hw/olc_interval.sv]
`timescale 1ns/10ps
// counts cycles between rising pulse edges of the metering input
module olc_interval #(
    parameter int IVL_W = olc_pkg::IVL_W
) (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic clear_i,
    input wire logic pulse_i,
    output logic [IVL_W-1:0] interval_o,
    output logic valid_o
);
    logic [2:0] sync_reg;
    logic level_reg;
    logic [IVL_W-1:0] cnt_reg;
    logic started_reg;
    wire rise = sync_reg[2] & sync_reg[1] & ~level_reg;
    wire fall = ~sync_reg[2] & ~sync_reg[1];
    wire sat = &cnt_reg;

    // three-stage sync, edge counted once stages two and three agree
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            sync_reg <= 3'h0;
            level_reg <= 1'b0;
        end
        else
        begin
            sync_reg <= {sync_reg[1:0], pulse_i};
            if (rise)
                level_reg <= 1'b1;
            else if (fall)
                level_reg <= 1'b0;
        end
    end

    // the first edge only starts timing, so no bogus interval is sent
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            cnt_reg <= '0;
            started_reg <= 1'b0;
            interval_o <= '0;
            valid_o <= 1'b0;
        end
        else
        begin
            valid_o <= 1'b0;
            if (clear_i)
            begin
                cnt_reg <= '0;
                started_reg <= 1'b0;
            end
            else if (rise)
            begin
                // the edge cycle counts, so a steady period of p cycles reads as p
                cnt_reg <= IVL_W'(1);
                started_reg <= 1'b1;
                if (started_reg)
                begin
                    interval_o <= cnt_reg;
                    valid_o <= 1'b1;
                end
            end
            else if (!sat)
                cnt_reg <= cnt_reg + 1'b1;
        end
    end
endmodule

// [bench/olc_meter_model.sv]
`timescale 1ns/10ps
// metering source: a square wave whose rate tracks the load power
module olc_meter_model (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic enable_i,
    input wire logic [23:0] period_i,
    output logic pulse_o
);
    logic [23:0] phase_reg;
    // a longer period stands for a lower power; a new period takes effect at once, in the cycle in progress
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            phase_reg <= 24'h000000;
        else if (!enable_i || phase_reg >= period_i - 24'h000001)
            phase_reg <= 24'h000000;
        else
            phase_reg <= phase_reg + 24'h000001;
    end
    // high for half the period; rests low when there is no load at all
    assign pulse_o = enable_i && (phase_reg < (period_i >> 1));
endmodule

// [bench/outlet_linkage_controller_tb_top.sv]
`timescale 1ns/10ps
module outlet_linkage_controller_tb_top;
    // short tick so the no-load window is 500 cycles
    localparam int TICK = 50;
    localparam logic [23:0] THRESH = 24'h000100;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic meter_en = 1'b0;
    logic master_en = 1'b0;
    logic [23:0] period = 24'h000100;
    logic pulse;
    logic slave;
    logic master;
    logic noload;
    logic wdt;
    logic [23:0] reading;
    int fail_count = 0;
    int total_checks = 0;
    int wdt_seen = 0;

    // 10 MHz core clock
    always #50 core_clk = ~core_clk;

    olc_top #(.TICK_CYC(TICK), .WDT_CYC(2000), .THRESH_IVL(THRESH)) u_olc_top (
        .core_clk_i(core_clk),
        .arst_n_i(arst_n),
        .meter_pulse_i(pulse),
        .master_enable_i(master_en),
        .slave_relay_drive_o(slave),
        .master_relay_drive_o(master),
        .noload_o(noload),
        .reading_o(reading),
        .wdt_reset_o(wdt)
    );

    olc_meter_model u_olc_meter_model (
        .core_clk_i(core_clk),
        .arst_n_i(arst_n),
        .enable_i(meter_en),
        .period_i(period),
        .pulse_o(pulse)
    );

    // watchdog pulses are tallied, since a one-cycle pulse is easy to miss
    always @(posedge core_clk)
    begin
        if (wdt === 1'b1)
            wdt_seen++;
    end

    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    // sample just after the edge so its updates have landed
    task automatic cycles(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic reset_outputs(input logic exp_master);
        check("slave", slave, 1'b0);
        check("master", master, exp_master);
        check("noload", noload, 1'b0);
        check("reading", reading, 24'h000000);
    endtask

    task automatic test_master();
        @(posedge core_clk);
        master_en <= 1'b1;
        cycles(1);
        check("master on", master, 1'b1);
        @(posedge core_clk);
        master_en <= 1'b0;
        cycles(1);
        check("master off", master, 1'b0);
    endtask

    // two whole sample groups so a mix of old and new periods has passed
    task automatic run_load(input logic [23:0] p, input logic exp_on);
        @(posedge core_clk);
        period <= p;
        meter_en <= 1'b1;
        cycles(int'(p) * 14 + 100);
        check("reading", reading, p);
        check("slave", slave, exp_on);
        check("noload", noload, 1'b0);
    endtask

    // metering stops, then restarts; the long gap must be trimmed away
    task automatic test_noload();
        @(posedge core_clk);
        meter_en <= 1'b0;
        cycles(150);
        check("noload early", noload, 1'b0);
        cycles(650);
        check("noload", noload, 1'b1);
        check("slave noload", slave, 1'b0);
        @(posedge core_clk);
        meter_en <= 1'b1;
        cycles(int'(period) * 7 + 100);
        check("reading trimmed", reading, period);
        check("noload back", noload, 1'b0);
        check("slave back", slave, 1'b1);
    endtask

    // reset in mid-run with the master enable held high
    task automatic test_second_reset();
        @(posedge core_clk);
        master_en <= 1'b1;
        arst_n <= 1'b0;
        cycles(2);
        reset_outputs(1'b0);
        @(posedge core_clk);
        arst_n <= 1'b1;
        cycles(2);
        check("master after", master, 1'b1);
    endtask

    initial
    begin
        cycles(10);
        reset_outputs(1'b0);
        @(posedge core_clk);
        arst_n <= 1'b1;
        test_master();
        run_load(24'h000100, 1'b0);
        run_load(24'h0000ff, 1'b1);
        test_noload();
        test_second_reset();
        check("watchdog pulses", 24'(wdt_seen), 24'h000000);
        conclude();
    end

    // about three times the expected run length
    initial
    begin
        #(100 * 30000);
        fail_count++;
        $display("unexpected timeout: run did not finish");
        conclude();
    end
endmodule
